// >>> design/stls_pkg.sv
// Constants shared by the torque limit selection block
package stls_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 6;
    localparam int DATA_W = 16;
    localparam int PCT_W = 10;   // Parameter limits, percent of rated torque
    localparam int OPT_W = 9;    // Option values, percent of momentary maximum
    localparam int LIM_W = 12;   // Internal limits in percent of rated torque
    localparam int TRQ_W = 13;   // Signed torque words, percent of rated torque
    localparam int PROD_W = 19;  // Option value times peak torque
    localparam int EVT_W = 3;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_STEADY_FWD = 6'h04;
    localparam logic [ADDR_W-1:0] OFS_STEADY_REV = 6'h08;
    localparam logic [ADDR_W-1:0] OFS_DESIG_FWD = 6'h0C;
    localparam logic [ADDR_W-1:0] OFS_DESIG_REV = 6'h10;
    localparam logic [ADDR_W-1:0] OFS_PEAK = 6'h14;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h18;
    localparam logic [ADDR_W-1:0] OFS_MASK = 6'h1C;
    localparam logic [ADDR_W-1:0] OFS_LIVE = 6'h20;
    localparam logic [ADDR_W-1:0] OFS_EFF_FWD = 6'h24;
    localparam logic [ADDR_W-1:0] OFS_EFF_REV = 6'h28;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTRL_SEL_LSB = 0;   // torque_cmd_input_select, 2 bits
    localparam int CTRL_ALLOC_LSB = 4; // limit_flag_output_alloc, 4 bits

    // Input selection codes
    localparam logic [1:0] SEL_PARAM_ONLY = 2'h0;
    localparam logic [1:0] SEL_OPT_CONT = 2'h1;
    localparam logic [1:0] SEL_OPT_GATED = 2'h3;

    // Status event bits
    localparam int EVT_FWD_LIMIT = 0;
    localparam int EVT_REV_LIMIT = 1;
    localparam int EVT_OPT_RANGE = 2;

    // ------------------------------------------------------------
    // Ranges and reset values
    // ------------------------------------------------------------
    localparam logic [PCT_W-1:0] PCT_MAX = 10'h320;      // 800 percent
    localparam logic [OPT_W-1:0] OPT_MAX = 9'h18F;       // 399 percent
    localparam logic [PROD_W-1:0] OPT_SCALE = 19'h00064; // 100 percent
    localparam logic [PCT_W-1:0] RST_STEADY = 10'h15E;   // 350 percent
    localparam logic [PCT_W-1:0] RST_DESIG = 10'h064;    // 100 percent
    localparam logic [PCT_W-1:0] RST_PEAK = 10'h12C;     // 300 percent
    localparam logic [1:0] RST_SEL = 2'h0;
    localparam logic [3:0] RST_ALLOC = 4'h0;

endpackage

// >>> design/stls_limit_pick.sv
// One direction's torque limit: smallest of the active sources
`timescale 1ns/1ps

module stls_limit_pick (
    // Parameter limits, percent of rated torque
    input wire logic [stls_pkg::PCT_W-1:0] steady_i,
    input wire logic [stls_pkg::PCT_W-1:0] desig_i,
    input wire logic desig_on_i,
    // Motor peak torque, percent of rated torque
    input wire logic [stls_pkg::PCT_W-1:0] peak_i,
    // Option limit already scaled to percent of rated torque
    input wire logic [stls_pkg::LIM_W-1:0] opt_i,
    input wire logic opt_on_i,
    // Resulting limit
    output logic [stls_pkg::LIM_W-1:0] limit_o
);

    // ------------------------------------------------------------
    // Selection
    // ------------------------------------------------------------

    // Parameter limits never exceed the peak torque; the peak is
    // always a candidate, so an idle designation adds nothing
    always_comb begin
        logic [stls_pkg::LIM_W-1:0] peak_w;
        logic [stls_pkg::LIM_W-1:0] cand;
        peak_w = stls_pkg::LIM_W'(peak_i);
        cand = peak_w;
        if (stls_pkg::LIM_W'(steady_i) < cand) begin
            cand = stls_pkg::LIM_W'(steady_i);
        end
        if (desig_on_i && (stls_pkg::LIM_W'(desig_i) < cand)) begin
            cand = stls_pkg::LIM_W'(desig_i);
        end
        if (opt_on_i && (opt_i < cand)) begin
            cand = opt_i;
        end
        limit_o = cand;
    end

endmodule

// >>> design/stls_torque_limit.sv
// Torque limit selection, clamping and limit-active indication
`timescale 1ns/1ps

// Behaviour
// - Several active limits: torque clamped to the smallest one.
// - Limit-active flag raised while clamping, only if allocated to an output.
// - Separate steady forward and reverse limits, 0 to 800 percent rated.
// - Parameter limits above motor peak torque are replaced by the peak.
// - Designated limits apply only while their direction's designation is on.
// - Selection one: option values used as limits continuously.
// - Option values in whole percent of peak torque, 0 to 399.
// - Continuous mode: option one limits forward, option two reverse.
// - Selection three: option values apply only under their designation.
// - Gated mode, forward designation on: option one limits forward.
// - Gated mode, reverse designation on: option two limits reverse.
module stls_torque_limit (
    // Clock, reset, enable
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Register port
    input wire logic [stls_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [stls_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [stls_pkg::DATA_W-1:0] reg_rdata_o,
    // Host motion controller
    input wire logic fwd_desig_i,
    input wire logic rev_desig_i,
    input wire logic axis_run_i,
    input wire logic [stls_pkg::OPT_W-1:0] opt_cmd1_i,
    input wire logic [stls_pkg::OPT_W-1:0] opt_cmd2_i,
    // Torque path
    input wire logic signed [stls_pkg::TRQ_W-1:0] torque_ref_i,
    output logic signed [stls_pkg::TRQ_W-1:0] torque_cmd_o,
    // Indications
    output logic torque_limit_active_flag_o,
    output logic irq_o
);

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [1:0] sel_ff, nxt_sel;
    logic [3:0] alloc_ff, nxt_alloc;
    logic [stls_pkg::PCT_W-1:0] steady_ff [2];
    logic [stls_pkg::PCT_W-1:0] nxt_steady [2];
    logic [stls_pkg::PCT_W-1:0] desig_ff [2];
    logic [stls_pkg::PCT_W-1:0] nxt_desig [2];
    logic [stls_pkg::PCT_W-1:0] peak_ff, nxt_peak;
    logic [stls_pkg::EVT_W-1:0] status_ff, nxt_status;
    logic [stls_pkg::EVT_W-1:0] mask_ff, nxt_mask;

    // Written percent limits saturate so the stored value stays in range,
    // rather than refusing an oversized write
    function automatic logic [stls_pkg::PCT_W-1:0] sat_pct(
        input logic [stls_pkg::DATA_W-1:0] val
    );
        if (val > stls_pkg::DATA_W'(stls_pkg::PCT_MAX)) begin
            sat_pct = stls_pkg::PCT_MAX;
        end else begin
            sat_pct = val[stls_pkg::PCT_W-1:0];
        end
    endfunction

    // ------------------------------------------------------------
    // Option value handling
    // ------------------------------------------------------------
    logic [stls_pkg::OPT_W-1:0] opt_sat [2];
    logic [stls_pkg::LIM_W-1:0] opt_rated [2];
    logic opt_on [2];
    logic desig_on [2];
    logic opt_bad;
    logic [stls_pkg::LIM_W-1:0] lim_w [2];

    // Option values above the accepted range are held at the top of it;
    // scaling to rated torque lets one comparator serve every source
    always_comb begin
        logic [stls_pkg::PROD_W-1:0] prod1;
        logic [stls_pkg::PROD_W-1:0] prod2;
        prod1 = '0;
        prod2 = '0;
        opt_sat[0] = (opt_cmd1_i > stls_pkg::OPT_MAX) ? stls_pkg::OPT_MAX
                                                       : opt_cmd1_i;
        opt_sat[1] = (opt_cmd2_i > stls_pkg::OPT_MAX) ? stls_pkg::OPT_MAX
                                                       : opt_cmd2_i;
        prod1 = stls_pkg::PROD_W'(opt_sat[0]) * stls_pkg::PROD_W'(peak_ff);
        prod2 = stls_pkg::PROD_W'(opt_sat[1]) * stls_pkg::PROD_W'(peak_ff);
        // Scaling truncates, so a limit never rounds up
        opt_rated[0] = stls_pkg::LIM_W'(prod1 / stls_pkg::OPT_SCALE);
        opt_rated[1] = stls_pkg::LIM_W'(prod2 / stls_pkg::OPT_SCALE);
        opt_bad = (opt_cmd1_i > stls_pkg::OPT_MAX) || (opt_cmd2_i > stls_pkg::OPT_MAX);
    end

    // Designations count only while the host runs the axis
    always_comb begin
        desig_on[0] = fwd_desig_i && axis_run_i;
        desig_on[1] = rev_desig_i && axis_run_i;
        // Code two is undefined and acts as parameters only
        for (int d = 0; d < 2; d++) begin
            unique case (sel_ff)
                stls_pkg::SEL_OPT_CONT: begin
                    opt_on[d] = 1'b1;
                end
                stls_pkg::SEL_OPT_GATED: begin
                    opt_on[d] = desig_on[d];
                end
                default: begin
                    opt_on[d] = 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Per-direction limit selection, index 0 forward, 1 reverse
    // ------------------------------------------------------------
    // Peak sits in every pick, so no limit can exceed it
    generate
        for (genvar g = 0; g < 2; g++) begin : g_dir
            stls_limit_pick u_pick (
                .steady_i(steady_ff[g]),
                .desig_i(desig_ff[g]),
                .desig_on_i(desig_on[g]),
                .peak_i(peak_ff),
                .opt_i(opt_rated[g]),
                .opt_on_i(opt_on[g]),
                .limit_o(lim_w[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Torque clamp and indication
    // ------------------------------------------------------------
    logic signed [stls_pkg::TRQ_W-1:0] torque_ff, nxt_torque;
    logic [stls_pkg::LIM_W-1:0] eff_ff [2];
    logic [stls_pkg::LIM_W-1:0] nxt_eff [2];
    logic [1:0] clamp_ff, nxt_clamp;
    logic flag_ff, nxt_flag;
    logic irq_ff, nxt_irq;

    // Clamp against the limits of this cycle; a pure limit change with no
    // torque demand beyond it does not count as restricting
    always_comb begin
        logic signed [stls_pkg::TRQ_W-1:0] fwd_s;
        logic signed [stls_pkg::TRQ_W-1:0] rev_s;
        fwd_s = signed'(stls_pkg::TRQ_W'(lim_w[0]));
        rev_s = -signed'(stls_pkg::TRQ_W'(lim_w[1]));
        nxt_eff[0] = lim_w[0];
        nxt_eff[1] = lim_w[1];
        nxt_clamp = 2'h0;
        nxt_torque = torque_ref_i;
        if (torque_ref_i > fwd_s) begin
            nxt_torque = fwd_s;
            nxt_clamp[0] = 1'b1;
        end else if (torque_ref_i < rev_s) begin
            nxt_torque = rev_s;
            nxt_clamp[1] = 1'b1;
        end
        // Flag reaches the output only when allocated
        nxt_flag = (|nxt_clamp) && (alloc_ff != 4'h0);
        // Interrupt trails status by one cycle
        nxt_irq = |(status_ff & mask_ff);
    end

    // Torque path registers
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            torque_ff <= '0;
            eff_ff[0] <= '0;
            eff_ff[1] <= '0;
            clamp_ff <= 2'h0;
            flag_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else if (ce_i) begin
            torque_ff <= nxt_torque;
            eff_ff[0] <= nxt_eff[0];
            eff_ff[1] <= nxt_eff[1];
            clamp_ff <= nxt_clamp;
            flag_ff <= nxt_flag;
            irq_ff <= nxt_irq;
        end
    end

    // ------------------------------------------------------------
    // Register writes and sticky events
    // ------------------------------------------------------------

    // Set beats clear so an event landing on a clearing write survives
    always_comb begin
        logic [stls_pkg::EVT_W-1:0] evt;
        logic [stls_pkg::EVT_W-1:0] clr;
        clr = '0;
        evt = '0;
        nxt_sel = sel_ff;
        nxt_alloc = alloc_ff;
        nxt_steady = steady_ff;
        nxt_desig = desig_ff;
        nxt_peak = peak_ff;
        nxt_mask = mask_ff;
        // Clamp events mark only the first clamped cycle;
        // a bad option value reports on every cycle
        evt[stls_pkg::EVT_FWD_LIMIT] = nxt_clamp[0] && !clamp_ff[0];
        evt[stls_pkg::EVT_REV_LIMIT] = nxt_clamp[1] && !clamp_ff[1];
        evt[stls_pkg::EVT_OPT_RANGE] = opt_bad;
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                stls_pkg::OFS_CTRL: begin
                    nxt_sel = reg_wdata_i[stls_pkg::CTRL_SEL_LSB +: 2];
                    nxt_alloc = reg_wdata_i[stls_pkg::CTRL_ALLOC_LSB +: 4];
                end
                stls_pkg::OFS_STEADY_FWD: nxt_steady[0] = sat_pct(reg_wdata_i);
                stls_pkg::OFS_STEADY_REV: nxt_steady[1] = sat_pct(reg_wdata_i);
                stls_pkg::OFS_DESIG_FWD: nxt_desig[0] = sat_pct(reg_wdata_i);
                stls_pkg::OFS_DESIG_REV: nxt_desig[1] = sat_pct(reg_wdata_i);
                stls_pkg::OFS_PEAK: nxt_peak = sat_pct(reg_wdata_i);
                stls_pkg::OFS_STATUS: clr = reg_wdata_i[stls_pkg::EVT_W-1:0];
                stls_pkg::OFS_MASK: nxt_mask = reg_wdata_i[stls_pkg::EVT_W-1:0];
                default: begin
                end
            endcase
        end
        nxt_status = (status_ff & ~clr) | evt;
    end

    // Configuration and status registers
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sel_ff <= stls_pkg::RST_SEL;
            alloc_ff <= stls_pkg::RST_ALLOC;
            // Steady limits come up at the no-limit default
            steady_ff[0] <= stls_pkg::RST_STEADY;
            steady_ff[1] <= stls_pkg::RST_STEADY;
            desig_ff[0] <= stls_pkg::RST_DESIG;
            desig_ff[1] <= stls_pkg::RST_DESIG;
            peak_ff <= stls_pkg::RST_PEAK;
            status_ff <= '0;
            mask_ff <= '0;
        end else if (ce_i) begin
            sel_ff <= nxt_sel;
            alloc_ff <= nxt_alloc;
            steady_ff <= nxt_steady;
            desig_ff <= nxt_desig;
            peak_ff <= nxt_peak;
            status_ff <= nxt_status;
            mask_ff <= nxt_mask;
        end
    end

    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    logic [stls_pkg::DATA_W-1:0] rdata_ff, nxt_rdata;

    // Data stand for one cycle only; unmapped offsets read zero
    always_comb begin
        nxt_rdata = '0;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                stls_pkg::OFS_CTRL: begin
                    nxt_rdata[stls_pkg::CTRL_SEL_LSB +: 2] = sel_ff;
                    nxt_rdata[stls_pkg::CTRL_ALLOC_LSB +: 4] = alloc_ff;
                end
                stls_pkg::OFS_STEADY_FWD: nxt_rdata = stls_pkg::DATA_W'(steady_ff[0]);
                stls_pkg::OFS_STEADY_REV: nxt_rdata = stls_pkg::DATA_W'(steady_ff[1]);
                stls_pkg::OFS_DESIG_FWD: nxt_rdata = stls_pkg::DATA_W'(desig_ff[0]);
                stls_pkg::OFS_DESIG_REV: nxt_rdata = stls_pkg::DATA_W'(desig_ff[1]);
                stls_pkg::OFS_PEAK: nxt_rdata = stls_pkg::DATA_W'(peak_ff);
                stls_pkg::OFS_STATUS: nxt_rdata = stls_pkg::DATA_W'(status_ff);
                stls_pkg::OFS_MASK: nxt_rdata = stls_pkg::DATA_W'(mask_ff);
                // Bit 0 forward clamp, bit 1 reverse, bit 3 flag
                stls_pkg::OFS_LIVE: nxt_rdata = {12'h000, flag_ff, 1'b0, clamp_ff};
                stls_pkg::OFS_EFF_FWD: nxt_rdata = stls_pkg::DATA_W'(eff_ff[0]);
                stls_pkg::OFS_EFF_REV: nxt_rdata = stls_pkg::DATA_W'(eff_ff[1]);
                default: nxt_rdata = '0;
            endcase
        end
    end

    // Read data register
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rdata_ff <= '0;
        end else if (ce_i) begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Outputs are bare registers
    assign reg_rdata_o = rdata_ff;
    assign torque_cmd_o = torque_ff;
    assign torque_limit_active_flag_o = flag_ff;
    assign irq_o = irq_ff;

endmodule

// >>> verification/stls_host_model.sv
// Host motion controller model: designation levels and option values
`timescale 1ns/1ps

module stls_host_model (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Bench command, taken while cmd_i is high
    input wire logic cmd_i,
    input wire logic [3:0] lag_i,
    input wire logic fwd_i,
    input wire logic rev_i,
    input wire logic run_i,
    input wire logic [stls_pkg::OPT_W-1:0] opt1_i,
    input wire logic [stls_pkg::OPT_W-1:0] opt2_i,
    // Output area towards the drive
    output logic fwd_desig_o = 1'b0,
    output logic rev_desig_o = 1'b0,
    output logic axis_run_o = 1'b0,
    output logic [stls_pkg::OPT_W-1:0] opt_cmd1_o = '0,
    output logic [stls_pkg::OPT_W-1:0] opt_cmd2_o = '0
);
    logic pend_ff = 1'b0;
    logic [3:0] wait_ff = 4'h0;

    // Output area updated lag_i+1 cycles after a command is taken, to act slow or prompt
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            pend_ff <= 1'b0;
            fwd_desig_o <= 1'b0;
            rev_desig_o <= 1'b0;
            axis_run_o <= 1'b0;
        end else if (cmd_i) begin
            pend_ff <= 1'b1;
            wait_ff <= lag_i;
        end else if (pend_ff && wait_ff != 4'h0) begin
            wait_ff <= wait_ff - 4'h1;
        end else if (pend_ff) begin
            pend_ff <= 1'b0;
            fwd_desig_o <= fwd_i;
            rev_desig_o <= rev_i;
            axis_run_o <= run_i;
            // Host never sends values beyond the accepted range
            opt_cmd1_o <= (opt1_i > stls_pkg::OPT_MAX) ? stls_pkg::OPT_MAX : opt1_i;
            opt_cmd2_o <= (opt2_i > stls_pkg::OPT_MAX) ? stls_pkg::OPT_MAX : opt2_i;
        end
    end
endmodule

// >>> verification/stls_torque_limit_sva.sv
// Port checker for the torque limit selection block
`timescale 1ns/1ps

module stls_torque_limit_sva (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Watched ports
    input wire logic ce_i,
    input wire logic [stls_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic [stls_pkg::DATA_W-1:0] reg_rdata_o,
    input wire logic signed [stls_pkg::TRQ_W-1:0] torque_ref_i,
    input wire logic signed [stls_pkg::TRQ_W-1:0] torque_cmd_o,
    input wire logic torque_limit_active_flag_o
);
    // ----------------------------------------
    // Clamp relations
    // ----------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    fwd_no_gain_a: assert property (ce_i && torque_ref_i >= 13'sd0 |=>
        torque_cmd_o >= 13'sd0 && torque_cmd_o <= $past(torque_ref_i))
        else $error("forward torque grew or flipped");
    rev_no_gain_a: assert property (ce_i && torque_ref_i < 13'sd0 |=>
        torque_cmd_o <= 13'sd0 && torque_cmd_o >= $past(torque_ref_i))
        else $error("reverse torque grew or flipped");
    flag_clamp_a: assert property (ce_i ##1 torque_limit_active_flag_o |->
        torque_cmd_o != $past(torque_ref_i))
        else $error("limit flag without clamping");
    zero_ref_a: assert property ((ce_i && torque_ref_i == 13'sd0) [*2] |=>
        torque_cmd_o == 13'sd0 && !torque_limit_active_flag_o)
        else $error("zero demand not passed through");
    fwd_peak_a: assert property (torque_cmd_o <= 13'sd800)
        else $error("forward torque above 800 percent");
    rev_peak_a: assert property (torque_cmd_o >= -13'sd800)
        else $error("reverse torque below -800 percent");
    limit_range_a: assert property (ce_i && reg_rd_i && reg_addr_i inside
        {6'h04, 6'h08, 6'h0C, 6'h10, 6'h24, 6'h28} |=> reg_rdata_o <= 16'h0320)
        else $error("limit register above 800 percent");
    freeze_a: assert property (!ce_i |=> $stable(torque_cmd_o))
        else $error("torque moved with enable low");
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the torque limit selection block
`timescale 1ns/1ps

module tb_top;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic [stls_pkg::ADDR_W-1:0] reg_addr_i = '0;
    logic [stls_pkg::DATA_W-1:0] reg_wdata_i = '0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [stls_pkg::DATA_W-1:0] reg_rdata_o;
    logic fwd_desig_i;
    logic rev_desig_i;
    logic axis_run_i;
    logic [stls_pkg::OPT_W-1:0] opt_cmd1_i;
    logic [stls_pkg::OPT_W-1:0] opt_cmd2_i;
    logic signed [stls_pkg::TRQ_W-1:0] torque_ref_i = '0;
    logic signed [stls_pkg::TRQ_W-1:0] torque_cmd_o;
    logic torque_limit_active_flag_o;
    logic irq_o;
    logic h_cmd = 1'b0;
    logic h_fwd = 1'b0;
    logic h_rev = 1'b0;
    logic h_run = 1'b0;
    logic [3:0] h_lag = 4'h0;
    logic [stls_pkg::OPT_W-1:0] h_opt1 = '0;
    logic [stls_pkg::OPT_W-1:0] h_opt2 = '0;
    int error_cnt = 0;
    int comparisons = 0;

    // 25 MHz system clock
    always #20 clk_sys_i = ~clk_sys_i;

    stls_torque_limit u_dut (.clk_sys_i, .rst_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
        .reg_rd_i, .reg_rdata_o, .fwd_desig_i, .rev_desig_i, .axis_run_i, .opt_cmd1_i,
        .opt_cmd2_i, .torque_ref_i, .torque_cmd_o, .torque_limit_active_flag_o, .irq_o);

    stls_host_model u_host (.clk_sys_i, .rst_i, .cmd_i(h_cmd), .lag_i(h_lag), .fwd_i(h_fwd),
        .rev_i(h_rev), .run_i(h_run), .opt1_i(h_opt1), .opt2_i(h_opt2),
        .fwd_desig_o(fwd_desig_i), .rev_desig_o(rev_desig_i), .axis_run_o(axis_run_i),
        .opt_cmd1_o(opt_cmd1_i), .opt_cmd2_o(opt_cmd2_i));

    // ----------------------------------------
    // Compare, bus and stimulus tasks
    // ----------------------------------------
    task automatic chk_reg(input logic [15:0] e, input logic [15:0] g, input string nm);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic chk_trq(input logic signed [12:0] e, input logic signed [12:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch torque_cmd_o expected %0d seen %0d", e, g);
        end
    endtask

    task automatic chk_bit(input logic e, input logic g, input string nm);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [5:0] a, input logic [15:0] e, input string nm);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        @(negedge clk_sys_i);
        chk_reg(e, reg_rdata_o, nm);
    endtask

    task automatic trq(input logic signed [12:0] r, input logic signed [12:0] e, input logic f);
        @(posedge clk_sys_i);
        torque_ref_i <= r;
        repeat (2) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        chk_trq(e, torque_cmd_o);
        chk_bit(f, torque_limit_active_flag_o, "flag");
    endtask

    task automatic host(input logic fw, rv, rn, input logic [8:0] o1, o2);
        @(posedge clk_sys_i);
        {h_fwd, h_rev, h_run, h_opt1, h_opt2, h_cmd} <= {fw, rv, rn, o1, o2, 1'b1};
        @(posedge clk_sys_i);
        h_cmd <= 1'b0;
        repeat (h_lag + 2) @(posedge clk_sys_i);
    endtask

    task automatic report_and_stop;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rd(6'h04, 16'h015E, "steady_fwd");
        rd(6'h08, 16'h015E, "steady_rev");
        wr(6'h04, 16'h0321);
        rd(6'h04, 16'h0320, "steady_fwd");
        wr(6'h3C, 16'hFFFF);
        rd(6'h3C, 16'h0000, "unmapped");
        trq(13'sd500, 13'sd300, 1'b0);
        trq(-13'sd500, -13'sd300, 1'b0);
        rd(6'h24, 16'h012C, "eff_fwd");
        wr(6'h04, 16'h00C8);
        wr(6'h08, 16'h0096);
        trq(13'sd500, 13'sd200, 1'b0);
        trq(-13'sd500, -13'sd150, 1'b0);
        // Flag shows only once allocated to an output
        wr(6'h00, 16'h0010);
        trq(13'sd500, 13'sd200, 1'b1);
        rd(6'h20, 16'h0009, "live");
        trq(-13'sd100, -13'sd100, 1'b0);
        wr(6'h00, 16'h0000);
        trq(13'sd500, 13'sd200, 1'b0);
        wr(6'h04, 16'h015E);
        wr(6'h08, 16'h015E);
        // Designated limits, host answering slowly, then promptly
        wr(6'h10, 16'h0032);
        h_lag = 4'h3;
        host(1'b1, 1'b1, 1'b0, 9'h000, 9'h000);
        trq(13'sd500, 13'sd300, 1'b0);
        host(1'b1, 1'b0, 1'b1, 9'h000, 9'h000);
        trq(13'sd500, 13'sd100, 1'b0);
        trq(-13'sd500, -13'sd300, 1'b0);
        h_lag = 4'h0;
        host(1'b0, 1'b1, 1'b1, 9'h000, 9'h000);
        trq(13'sd500, 13'sd300, 1'b0);
        trq(-13'sd500, -13'sd50, 1'b0);
        wr(6'h0C, 16'h0320);
        wr(6'h04, 16'h0050);
        host(1'b1, 1'b1, 1'b1, 9'h000, 9'h000);
        trq(13'sd500, 13'sd80, 1'b0);
        wr(6'h04, 16'h015E);
        wr(6'h10, 16'h0064);
        // Continuous option limits: 50 and 20 percent of a 300 peak
        wr(6'h00, 16'h0001);
        host(1'b0, 1'b0, 1'b1, 9'h032, 9'h014);
        trq(13'sd500, 13'sd150, 1'b0);
        trq(-13'sd500, -13'sd60, 1'b0);
        host(1'b0, 1'b0, 1'b1, 9'h18F, 9'h000);
        trq(13'sd500, 13'sd300, 1'b0);
        trq(-13'sd500, 13'sd0, 1'b0);
        // Option limits gated by designation
        wr(6'h00, 16'h0003);
        host(1'b0, 1'b0, 1'b1, 9'h032, 9'h014);
        trq(13'sd500, 13'sd300, 1'b0);
        trq(-13'sd500, -13'sd300, 1'b0);
        host(1'b1, 1'b0, 1'b1, 9'h032, 9'h014);
        trq(13'sd500, 13'sd150, 1'b0);
        trq(-13'sd500, -13'sd300, 1'b0);
        host(1'b0, 1'b1, 1'b1, 9'h032, 9'h014);
        trq(13'sd500, 13'sd300, 1'b0);
        trq(-13'sd500, -13'sd60, 1'b0);
        // Clamp event, mask and write-one clear
        wr(6'h00, 16'h0000);
        trq(13'sd0, 13'sd0, 1'b0);
        wr(6'h18, 16'h0007);
        wr(6'h1C, 16'h0001);
        rd(6'h18, 16'h0000, "status");
        trq(13'sd500, 13'sd300, 1'b0);
        chk_bit(1'b1, irq_o, "irq");
        rd(6'h18, 16'h0001, "status");
        wr(6'h1C, 16'h0000);
        repeat (2) @(negedge clk_sys_i);
        chk_bit(1'b0, irq_o, "irq");
        wr(6'h1C, 16'h0001);
        repeat (2) @(negedge clk_sys_i);
        chk_bit(1'b1, irq_o, "irq");
        wr(6'h18, 16'h0001);
        repeat (2) @(negedge clk_sys_i);
        chk_bit(1'b0, irq_o, "irq");
        // Enable low holds the clamped output
        @(posedge clk_sys_i);
        ce_i <= 1'b0;
        torque_ref_i <= 13'sd10;
        repeat (3) @(posedge clk_sys_i);
        ce_i <= 1'b1;
        chk_trq(13'sd300, torque_cmd_o);
        trq(13'sd10, 13'sd10, 1'b0);
        report_and_stop();
    end

    // Watchdog, far beyond the few hundred cycles the scenarios need
    initial begin
        #100000;
        error_cnt++;
        report_and_stop();
    end
endmodule

bind stls_torque_limit stls_torque_limit_sva u_sva (.clk_sys_i, .rst_i, .ce_i, .reg_addr_i,
    .reg_rd_i, .reg_rdata_o, .torque_ref_i, .torque_cmd_o, .torque_limit_active_flag_o);
